// File: bench/test_upf_packet_fifo.sv
`timescale 1ns/10ps
`default_nettype none
////////////////////////////////////////
module test_upf_packet_fifo
  import upf_pkg::*;
;
  logic       clk;
  logic       rst_n;
  logic       hs;
  logic       multi;
  logic       uo_valid;
  logic       uo_ready;
  upf_uo_s    uo_beat;
  logic       ui_valid;
  logic       ui_ready;
  upf_ui_s    ui_beat;
  logic       ui_ack;
  logic       ui_nak;
  logic       mtx_valid;
  logic       mtx_ready;
  upf_byte_s  mtx_beat;
  logic       mrx_valid;
  logic       mrx_ready;
  upf_byte_s  mrx_beat;
  logic       stall;
  logic       go;
  logic [7:0] len;
  int         error_cnt;
  int         samples_checked;
  logic [7:0] pk[$];
  upf_byte_s  exp_q[$];
  upf_byte_s  mtxq[$];
  upf_ui_s    uiq[$];

  upf_packet_fifo #(
    .RX_BYTES (64),
    .TX_BYTES (32),
    .MTX_BYTES(32),
    .HS_BLOCK (16),
    .FS_BLOCK (8)
  ) i_upf_packet_fifo (
    .clk_i        (clk),
    .rst_n_i      (rst_n),
    .hs_mode_i    (hs),
    .encap_multi_i(multi),
    .uo_valid_i   (uo_valid),
    .uo_ready_o   (uo_ready),
    .uo_beat_i    (uo_beat),
    .ui_valid_o   (ui_valid),
    .ui_ready_i   (ui_ready),
    .ui_beat_o    (ui_beat),
    .ui_ack_i     (ui_ack),
    .ui_nak_i     (ui_nak),
    .mtx_valid_o  (mtx_valid),
    .mtx_ready_i  (mtx_ready),
    .mtx_beat_o   (mtx_beat),
    .mrx_valid_i  (mrx_valid),
    .mrx_ready_o  (mrx_ready),
    .mrx_beat_i   (mrx_beat)
  );

  upf_mac_model i_upf_mac_model (
    .clk_i      (clk),
    .rst_n_i    (rst_n),
    .stall_i    (stall),
    .go_i       (go),
    .len_i      (len),
    .mtx_ready_o(mtx_ready),
    .mrx_valid_o(mrx_valid),
    .mrx_ready_i(mrx_ready),
    .mrx_beat_o (mrx_beat)
  );

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  always @(posedge clk) begin
    if (mtx_valid === 1'b1 && mtx_ready === 1'b1) mtxq.push_back(mtx_beat);
    if (ui_valid === 1'b1 && ui_ready === 1'b1) uiq.push_back(ui_beat);
  end

  task automatic test_done();
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] want);
    samples_checked++;
    if (seen !== want) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", what, want, seen);
    end
  endtask

  // Ready is combinational, so it is judged at the falling edge when settled.
  task automatic uo_send(input logic bad, input int gap);
    int n;
    for (int i = 0; i < pk.size(); i++) begin
      if (gap > 0 && i == pk.size() - 1) begin
        uo_valid <= 1'b0;
        repeat (gap) @(negedge clk);
        check("mtx_early", 32'(mtx_valid), 32'h0);
        @(posedge clk);
      end
      uo_valid <= 1'b1;
      uo_beat <= '{data: pk[i], last: i == pk.size() - 1, err: bad && i == pk.size() - 1};
      n = 0;
      do begin
        @(negedge clk);
        n++;
      end while (uo_ready !== 1'b1 && n < 2000);
      if (n >= 2000) begin
        check("uo_wait", 32'h0, 32'h1);
        test_done();
      end
      @(posedge clk);
    end
    uo_valid <= 1'b0;
    @(posedge clk);
  endtask

  task automatic chk_mtx();
    int n;
    n = 0;
    while (mtxq.size() < exp_q.size() && n < 3000) begin
      @(posedge clk);
      n++;
    end
    if (n >= 3000) begin
      check("mtx_wait", 32'h0, 32'h1);
      test_done();
    end
    repeat (10) @(posedge clk);
    check("mtx_count", 32'(mtxq.size()), 32'(exp_q.size()));
    foreach (exp_q[k]) if (k < mtxq.size()) check("mtx_beat", 32'(mtxq[k]), 32'(exp_q[k]));
    mtxq.delete();
    exp_q.delete();
  endtask

  task automatic ui_pkt(input int n_b, input logic [7:0] base, input logic eof, input logic ok);
    int n;
    n = 0;
    while (!(uiq.size() > 0 && uiq[$].last === 1'b1) && n < 3000) begin
      @(posedge clk);
      n++;
    end
    if (n >= 3000) begin
      check("ui_wait", 32'h0, 32'h1);
      test_done();
    end
    check("ui_len", 32'(uiq.size()), 32'(n_b));
    foreach (uiq[k]) check("ui_beat", 32'(uiq[k]), 32'({base + k[7:0], eof && k == n_b - 1, k == n_b - 1}));
    uiq.delete();
    repeat (4) @(posedge clk);
    check("ui_held", 32'(uiq.size()), 32'h0);
    ui_ack <= ok;
    ui_nak <= !ok;
    @(posedge clk);
    ui_ack <= 1'b0;
    ui_nak <= 1'b0;
  endtask

  task automatic mac_frame(input logic mode, input logic [7:0] n_b);
    hs <= mode;
    go <= 1'b1;
    len <= n_b;
    @(posedge clk);
    go <= 1'b0;
  endtask

  task automatic sc_single();
    pk.delete();
    for (int i = 0; i < 10; i++) begin
      pk.push_back(8'h10 + i[7:0]);
      exp_q.push_back('{data: 8'h10 + i[7:0], last: i == 9});
    end
    uo_send(1'b0, 20);
    chk_mtx();
  endtask

  task automatic sc_bad();
    pk = '{8'h51, 8'h52, 8'h53, 8'h54, 8'h55};
    uo_send(1'b1, 0);
    pk = '{8'h61, 8'h62, 8'h63};
    exp_q = '{'{8'h61, 1'b0}, '{8'h62, 1'b0}, '{8'h63, 1'b1}};
    uo_send(1'b0, 0);
    chk_mtx();
  endtask

  task automatic sc_multi();
    multi <= 1'b1;
    @(posedge clk);
    pk = '{8'h00, 8'h00, 8'h03, 8'h00, 8'hc1, 8'hc2, 8'hc3, 8'h02, 8'h00, 8'hd1, 8'hd2};
    exp_q = '{'{8'hc1, 1'b0}, '{8'hc2, 1'b0}, '{8'hc3, 1'b1}, '{8'hd1, 1'b0}, '{8'hd2, 1'b1}};
    uo_send(1'b0, 0);
    chk_mtx();
    mac_frame(1'b1, 8'd5);
    ui_pkt(5, 8'ha0, 1'b1, 1'b1);
    multi <= 1'b0;
  endtask

  task automatic sc_rx();
    ui_ready <= 1'b0;
    mac_frame(1'b0, 8'd12);
    repeat (40) @(posedge clk);
    @(negedge clk);
    check("ui_hold", 32'(ui_valid), 32'h1);
    check("ui_first", 32'(ui_beat), 32'({8'ha0, 1'b0, 1'b0}));
    @(posedge clk);
    ui_ready <= 1'b1;
    ui_pkt(8, 8'ha0, 1'b0, 1'b0);
    ui_pkt(8, 8'ha0, 1'b0, 1'b1);
    ui_pkt(4, 8'ha8, 1'b1, 1'b1);
    mac_frame(1'b1, 8'd12);
    ui_pkt(12, 8'ha0, 1'b1, 1'b1);
  endtask

  task automatic sc_fill();
    int   i;
    int   low;
    int   n;
    logic ok;
    i = 0;
    low = 0;
    n = 0;
    stall <= 1'b1;
    while (i < 80 && n < 4000) begin
      uo_valid <= 1'b1;
      uo_beat <= '{data: i[7:0], last: i % 8 == 7, err: 1'b0};
      @(negedge clk);
      n++;
      ok = uo_ready === 1'b1;
      low = ok ? 0 : low + 1;
      @(posedge clk);
      if (low == 40) stall <= 1'b0;
      if (ok) begin
        exp_q.push_back('{data: i[7:0], last: i % 8 == 7});
        i++;
      end
    end
    if (n >= 4000) begin
      check("fill_wait", 32'h0, 32'h1);
      test_done();
    end
    uo_valid <= 1'b0;
    check("uo_refused", 32'(stall), 32'h0);
    stall <= 1'b0;
    chk_mtx();
  endtask

  initial begin
    rst_n = 1'b0;
    hs = 1'b0;
    multi = 1'b0;
    uo_valid = 1'b0;
    uo_beat = '0;
    ui_ready = 1'b1;
    ui_ack = 1'b0;
    ui_nak = 1'b0;
    stall = 1'b0;
    go = 1'b0;
    len = 8'h00;
    error_cnt = 0;
    samples_checked = 0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    sc_single();
    sc_bad();
    sc_multi();
    sc_rx();
    sc_fill();
    test_done();
  end
endmodule // test_upf_packet_fifo
`default_nettype wire

// File: bench/upf_mac_model.sv
`timescale 1ns/10ps
`default_nettype none
////////////////////////////////////////
module upf_mac_model
  import upf_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  // Bench control
  input  wire logic       stall_i,
  input  wire logic       go_i,
  input  wire logic [7:0] len_i,
  // MAC transmit path
  output logic            mtx_ready_o,
  // MAC receive path
  output logic            mrx_valid_o,
  input  wire logic       mrx_ready_i,
  output upf_byte_s       mrx_beat_o
);
  logic [7:0] left;
  logic [7:0] idx;
  logic [7:0] tick;

  // A stalled MAC holds ready low so that data backs up into the buffers.
  assign mtx_ready_o = !stall_i;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      left <= 8'h00;
      idx  <= 8'h00;
    end else if (go_i) begin
      left <= len_i;
      idx  <= 8'h00;
    end else if (mrx_valid_o && mrx_ready_i) begin
      left <= left - 8'h01;
      idx  <= idx + 8'h01;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      tick <= 8'h00;
    end else begin
      tick <= tick + 8'h01;
    end
  end

  // Outside a frame the lines churn, so stale data is never taken as new.
  assign mrx_valid_o     = left != 8'h00;
  assign mrx_beat_o.data = mrx_valid_o ? 8'ha0 + idx : tick;
  assign mrx_beat_o.last = mrx_valid_o ? left == 8'h01 : tick[0];
endmodule // upf_mac_model
`default_nettype wire

// File: inc/upf_consts.svh
`ifndef UPF_CONSTS_SVH
`define UPF_CONSTS_SVH

// Buffer sizes in bytes.
`define UPF_RX_BYTES 20480
`define UPF_TX_BYTES 8192
`define UPF_MTX_BYTES 2048
`define UPF_MRX_BYTES 128
`define UPF_STAGE_DEPTH 4

// Bulk-in block sizes in bytes.
`define UPF_HS_BLOCK 512
`define UPF_FS_BLOCK 64

// Complete frames the MAC-side transmit buffer may hold.
`define UPF_MTX_FRAMES 2

`endif

// File: inc/upf_pkg.sv
package upf_pkg;

  typedef struct packed {
    logic [7:0] data;
    logic       last;
    logic       err;
  } upf_uo_s;

  typedef struct packed {
    logic [7:0] data;
    logic       last;
  } upf_byte_s;

  typedef struct packed {
    logic [7:0] data;
    logic       eof;
    logic       last;
  } upf_ui_s;

  typedef enum logic [2:0] {
    UI_IDLE = 3'b001,
    UI_SEND = 3'b010,
    UI_WAIT = 3'b100
  } upf_ui_state_e;

  typedef enum logic [2:0] {
    PS_HDR0 = 3'b001,
    PS_HDR1 = 3'b010,
    PS_BODY = 3'b100
  } upf_parse_e;

endpackage

// File: verilog/upf_packet_fifo.sv
// Behaviour
// [R1] - Internal store splits into 20 KB receive and 8 KB transmit buffers.
// [R2] - Bulk-out bytes are written straight into the transmit buffer.
// [R3] - Controller separates Ethernet frames from buffered USB data toward the MAC.
// [R4] - Frames from the MAC are written straight into the receive buffer.
// [R5] - Bulk-in data leaves in blocks of 512 bytes (HS) or 64 (FS).
// [R6] - A bad bulk-out packet is discarded by rewinding the transmit write pointer.
// [R7] - Bulk-in transmitter fetches frames from receive buffer and builds bulk-in packets.
// [R8] - An unacknowledged bulk-in packet can be sent again unchanged; with encap_multi_i a resend may run into later frames.
// [R9] - Receive read head advances only after the host acknowledges the packet.
// [R10] - Both directions support many frames per packet or one frame per packet.
// [R11] - MAC side has a 2 KB transmit FIFO and 128-byte receive FIFO.
// [R12] - MAC transmit FIFO is store-and-forward and holds at most two frames.
// [R13] - MAC-side receive and transmit paths are separate and independent.
// [R14] - Bulk-out side sees not-ready when the transmit buffer has no space.
`timescale 1ns/10ps
`default_nettype none
`include "upf_consts.svh"

////////////////////////////////////////////////////////////////////////////////
module upf_stream_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = `UPF_STAGE_DEPTH
) (
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  // Fill side
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  input  wire logic [W-1:0] in_data_i,
  // Drain side
  output logic              out_valid_o,
  input  wire logic         out_ready_i,
  output logic [W-1:0]      out_data_o
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  if (DEPTH < 2 || W < 1) begin : g_bad_cfg
    $error("upf_stream_fifo needs DEPTH of at least 2");
  end

  logic [W-1:0]  mem [DEPTH];
  logic [AW-1:0] wr_idx;
  logic [AW-1:0] rd_idx;
  logic [CW-1:0] count;
  logic          push;
  logic          pop;

  assign in_ready_o  = (count != CW'(DEPTH));
  assign out_valid_o = (count != '0);
  assign out_data_o  = mem[rd_idx];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wr_idx] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      wr_idx <= '0;
      rd_idx <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_idx <= (wr_idx == AW'(DEPTH - 1)) ? '0 : wr_idx + 1'b1;
      end
      if (pop) begin
        rd_idx <= (rd_idx == AW'(DEPTH - 1)) ? '0 : rd_idx + 1'b1;
      end
      count <= count + CW'(push) - CW'(pop);
    end
  end

  fifo_bound_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (count == CW'(DEPTH)) && in_valid_i && !pop |=> count == CW'(DEPTH))
    else $error("fifo count moved past depth");

endmodule // upf_stream_fifo

////////////////////////////////////////////////////////////////////////////////
module upf_packet_fifo
  import upf_pkg::*;
#(
  parameter int RX_BYTES    = `UPF_RX_BYTES,
  parameter int TX_BYTES    = `UPF_TX_BYTES,
  parameter int MTX_BYTES   = `UPF_MTX_BYTES,
  parameter int MRX_BYTES   = `UPF_MRX_BYTES,
  parameter int STAGE_DEPTH = `UPF_STAGE_DEPTH,
  parameter int HS_BLOCK    = `UPF_HS_BLOCK,
  parameter int FS_BLOCK    = `UPF_FS_BLOCK
) (
  // Clock and reset
  input  wire logic      clk_i,
  input  wire logic      rst_n_i,
  // Mode
  input  wire logic      hs_mode_i,
  input  wire logic      encap_multi_i,
  // Bulk-out pipe from the usb_device_engine
  input  wire logic      uo_valid_i,
  output logic           uo_ready_o,
  input  wire upf_uo_s   uo_beat_i,
  // Bulk-in pipe to the usb_device_engine
  output logic           ui_valid_o,
  input  wire logic      ui_ready_i,
  output upf_ui_s        ui_beat_o,
  input  wire logic      ui_ack_i,
  input  wire logic      ui_nak_i,
  // MAC transmit path
  output logic           mtx_valid_o,
  input  wire logic      mtx_ready_i,
  output upf_byte_s      mtx_beat_o,
  // MAC receive path
  input  wire logic      mrx_valid_i,
  output logic           mrx_ready_o,
  input  wire upf_byte_s mrx_beat_i
);
  localparam int TAW = $clog2(TX_BYTES);
  localparam int TCW = $clog2(TX_BYTES + 1);
  localparam int RAW = $clog2(RX_BYTES);
  localparam int RCW = $clog2(RX_BYTES + 1);
  localparam int MAW = $clog2(MTX_BYTES);
  localparam int MCW = $clog2(MTX_BYTES + 1);
  localparam int UCW = $clog2(HS_BLOCK + 1);

  if (TX_BYTES < 2 || RX_BYTES < 2 || MTX_BYTES < 2 || FS_BLOCK < 1 ||
      HS_BLOCK < FS_BLOCK) begin : g_bad_cfg
    $error("upf_packet_fifo parameters out of range");
  end

  //////////////////////////////////////////////////////////////////////////////
  // Bulk-out staging and transmit buffer.
  upf_uo_s       st;
  logic          st_valid;
  logic          st_ready;
  upf_byte_s     tx_mem [TX_BYTES];
  logic [TAW-1:0] tx_wp;
  logic [TAW-1:0] tx_cp;
  logic [TAW-1:0] tx_rp;
  logic [TCW-1:0] tx_avail;
  logic [TCW-1:0] tx_pend;
  logic          tx_full;
  logic          accept;
  logic          bad_pkt;
  logic          good_pkt;
  logic          wr_en;
  logic          frame_end;
  upf_parse_e    ps;
  logic [15:0]   flen;
  logic          tx_rd;

  upf_stream_fifo #(.W($bits(upf_uo_s)), .DEPTH(STAGE_DEPTH)) u_stage (
    .clk_i       (clk_i),
    .rst_n_i     (rst_n_i),
    .in_valid_i  (uo_valid_i),
    .in_ready_o  (uo_ready_o),
    .in_data_i   (uo_beat_i),
    .out_valid_o (st_valid),
    .out_ready_i (st_ready),
    .out_data_o  (st)
  );

  // A bad final byte is never stored, so it needs no space.
  assign tx_full   = (tx_avail + tx_pend) == TCW'(TX_BYTES);             // [R1]
  assign st_ready  = !tx_full || (st.last && st.err);                     // [R14]
  assign accept    = st_valid && st_ready;
  assign bad_pkt   = accept && st.last && st.err;
  assign good_pkt  = accept && st.last && !st.err;
  // Length headers in packed mode mark frame edges and are not stored.
  assign wr_en     = accept && !bad_pkt && (!encap_multi_i || ps == PS_BODY); // [R10]
  assign frame_end = encap_multi_i ? (flen == 16'h0001) : st.last;        // [R3]

  always_ff @(posedge clk_i) begin
    if (wr_en) begin
      tx_mem[tx_wp] <= '{data: st.data, last: frame_end};                 // [R2]
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      tx_wp   <= '0;
      tx_cp   <= '0;
      tx_pend <= '0;
    end else if (bad_pkt) begin
      tx_wp   <= tx_cp;                                                   // [R6]
      tx_pend <= '0;
    end else begin
      if (wr_en) begin
        tx_wp <= (tx_wp == TAW'(TX_BYTES - 1)) ? '0 : tx_wp + 1'b1;
      end
      if (good_pkt) begin
        tx_cp   <= wr_en ? ((tx_wp == TAW'(TX_BYTES - 1)) ? '0 : tx_wp + 1'b1) : tx_wp;
        tx_pend <= '0;
      end else if (wr_en) begin
        tx_pend <= tx_pend + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      tx_avail <= '0;
    end else begin
      tx_avail <= tx_avail + (good_pkt ? tx_pend + TCW'(wr_en) : '0) - TCW'(tx_rd);
    end
  end

  // Packed mode: each frame follows a two-byte little-endian length.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      ps   <= PS_HDR0;
      flen <= '0;
    end else if (bad_pkt || !encap_multi_i) begin
      ps <= PS_HDR0;
    end else if (accept) begin
      unique case (ps)
        PS_HDR0: begin
          flen[7:0] <= st.data;
          ps        <= PS_HDR1;
        end
        PS_HDR1: begin
          flen[15:8] <= st.data;
          ps         <= ({st.data, flen[7:0]} == 16'h0000) ? PS_HDR0 : PS_BODY; // [R3]
        end
        PS_BODY: begin
          flen <= flen - 1'b1;
          if (flen == 16'h0001) begin
            ps <= PS_HDR0;
          end
        end
      endcase
    end
  end

  bad_rewind_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R6]
    bad_pkt |=> (tx_wp == $past(tx_cp)) && (tx_pend == '0) && (tx_avail <= $past(tx_avail)))
    else $error("bad packet was not rewound");

  tx_full_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R14]
    tx_full && !bad_pkt |=> (tx_avail + tx_pend) == TCW'(TX_BYTES) || $past(tx_rd))
    else $error("transmit buffer overwritten while full");

  //////////////////////////////////////////////////////////////////////////////
  // MAC transmit buffer, store-and-forward.
  upf_byte_s     mtx_mem [MTX_BYTES];
  logic [MAW-1:0] mtx_wi;
  logic [MAW-1:0] mtx_ri;
  logic [MCW-1:0] mtx_cnt;
  logic [1:0]    mtx_frames;
  logic          mtx_load;

  assign tx_rd    = (tx_avail != '0) && (mtx_cnt != MCW'(MTX_BYTES)) &&
                    (mtx_frames != 2'(`UPF_MTX_FRAMES));                  // [R12]
  assign mtx_load = (mtx_frames != '0) && (!mtx_valid_o || mtx_ready_i); // [R12]

  always_ff @(posedge clk_i) begin
    if (tx_rd) begin
      mtx_mem[mtx_wi] <= tx_mem[tx_rp];                                   // [R3]
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      tx_rp      <= '0;
      mtx_wi     <= '0;
      mtx_ri     <= '0;
      mtx_cnt    <= '0;
      mtx_frames <= '0;
    end else begin
      if (tx_rd) begin
        tx_rp  <= (tx_rp == TAW'(TX_BYTES - 1)) ? '0 : tx_rp + 1'b1;
        mtx_wi <= (mtx_wi == MAW'(MTX_BYTES - 1)) ? '0 : mtx_wi + 1'b1;
      end
      if (mtx_load) begin
        mtx_ri <= (mtx_ri == MAW'(MTX_BYTES - 1)) ? '0 : mtx_ri + 1'b1;
      end
      mtx_cnt    <= mtx_cnt + MCW'(tx_rd) - MCW'(mtx_load);
      mtx_frames <= mtx_frames + 2'(tx_rd && tx_mem[tx_rp].last)
                    - 2'(mtx_load && mtx_mem[mtx_ri].last);               // [R11]
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      mtx_valid_o <= 1'b0;
      mtx_beat_o  <= '0;
    end else if (mtx_load) begin
      mtx_valid_o <= 1'b1;
      mtx_beat_o  <= mtx_mem[mtx_ri];
    end else if (mtx_ready_i) begin
      mtx_valid_o <= 1'b0;
    end
  end

  mtx_two_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R12]
    mtx_frames == 2'(`UPF_MTX_FRAMES) |=> mtx_frames <= 2'(`UPF_MTX_FRAMES))
    else $error("more than two frames held");

  mtx_whole_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R12]
    $rose(mtx_valid_o) |-> $past(mtx_frames) != '0)
    else $error("frame released before fully stored");

  //////////////////////////////////////////////////////////////////////////////
  // MAC receive FIFO and receive buffer.
  upf_byte_s     rf;
  logic          rf_valid;
  logic          rf_ready;
  logic          rx_wr;
  upf_byte_s     rx_mem [RX_BYTES];
  logic [RAW-1:0] rx_wp;
  logic [RAW-1:0] rx_head;
  logic [RAW-1:0] rx_spec;
  logic [RCW-1:0] rx_pend;
  logic [RCW-1:0] rx_held;
  logic [RCW-1:0] rx_sent;
  logic [RCW-1:0] rx_left;

  // Separate instance, so receive never waits on transmit.
  upf_stream_fifo #(.W($bits(upf_byte_s)), .DEPTH(MRX_BYTES)) u_mrx ( // [R11] [R13]
    .clk_i       (clk_i),
    .rst_n_i     (rst_n_i),
    .in_valid_i  (mrx_valid_i),
    .in_ready_o  (mrx_ready_o),
    .in_data_i   (mrx_beat_i),
    .out_valid_o (rf_valid),
    .out_ready_i (rf_ready),
    .out_data_o  (rf)
  );

  // Space counts bytes not yet acknowledged, so a retry never sees overwritten data.
  assign rf_ready = (rx_held + rx_pend) != RCW'(RX_BYTES);               // [R1]
  assign rx_wr    = rf_valid && rf_ready;
  assign rx_left  = rx_held - rx_sent;

  always_ff @(posedge clk_i) begin
    if (rx_wr) begin
      rx_mem[rx_wp] <= rf;                                                // [R4]
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rx_wp   <= '0;
      rx_pend <= '0;
    end else if (rx_wr) begin
      rx_wp   <= (rx_wp == RAW'(RX_BYTES - 1)) ? '0 : rx_wp + 1'b1;
      rx_pend <= rf.last ? '0 : rx_pend + 1'b1;                          // [R4]
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Bulk-in transmitter.
  upf_ui_state_e ui_st;
  logic [UCW-1:0] ui_cnt;
  logic [UCW-1:0] blk;
  logic          ui_load;
  logic          ui_end;
  logic          ui_ack;
  logic          ui_nak;

  assign blk     = hs_mode_i ? UCW'(HS_BLOCK) : UCW'(FS_BLOCK);          // [R5]
  assign ui_load = (ui_st == UI_SEND) && !ui_end && (rx_left != '0) &&
                   (!ui_valid_o || ui_ready_i);                           // [R7]
  assign ui_ack  = (ui_st == UI_WAIT) && ui_ack_i;
  assign ui_nak  = (ui_st == UI_WAIT) && ui_nak_i && !ui_ack_i;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      ui_st  <= UI_IDLE;
      ui_cnt <= '0;
      ui_end <= 1'b0;
    end else begin
      unique case (ui_st)
        UI_IDLE: begin
          ui_cnt <= '0;
          ui_end <= 1'b0;
          if (rx_left != '0) begin
            ui_st <= UI_SEND;
          end
        end
        UI_SEND: begin
          if (ui_load) begin
            ui_cnt <= ui_cnt + 1'b1;
            ui_end <= (ui_cnt + 1'b1 == blk) || (!encap_multi_i && rx_mem[rx_spec].last) ||
                      (rx_left == RCW'(1));                               // [R5] [R10]
          end
          if (ui_valid_o && ui_ready_i && ui_beat_o.last) begin
            ui_st <= UI_WAIT;
          end
        end
        UI_WAIT: begin
          if (ui_ack || ui_nak) begin
            ui_st <= UI_IDLE;                                             // [R8]
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      ui_valid_o <= 1'b0;
      ui_beat_o  <= '0;
    end else if (ui_load) begin
      ui_valid_o <= 1'b1;
      ui_beat_o  <= '{data: rx_mem[rx_spec].data, eof: rx_mem[rx_spec].last,
                      last: (ui_cnt + 1'b1 == blk) || (!encap_multi_i && rx_mem[rx_spec].last)
                            || (rx_left == RCW'(1))};                     // [R5] [R10]
    end else if (ui_ready_i) begin
      ui_valid_o <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rx_head <= '0;
      rx_spec <= '0;
      rx_sent <= '0;
    end else if (ui_ack) begin
      rx_head <= rx_spec;                                                 // [R9]
      rx_sent <= '0;
    end else if (ui_nak) begin
      rx_spec <= rx_head;                                                 // [R8]
      rx_sent <= '0;
    end else if (ui_load) begin
      rx_spec <= (rx_spec == RAW'(RX_BYTES - 1)) ? '0 : rx_spec + 1'b1;
      rx_sent <= rx_sent + 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rx_held <= '0;
    end else begin
      rx_held <= rx_held + ((rx_wr && rf.last) ? rx_pend + 1'b1 : '0)
                 - (ui_ack ? rx_sent : '0);                               // [R9]
    end
  end

  head_hold_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R9]
    (rx_head != $past(rx_head)) |-> $past(ui_st == UI_WAIT && ui_ack_i))
    else $error("read head moved without acknowledge");

  retry_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R8]
    ui_nak |=> (rx_spec == rx_head) && (rx_sent == '0) && (ui_st == UI_IDLE))
    else $error("packet not rewound for retry");

  block_size_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R5]
    ui_load |-> (ui_cnt < blk) ##1 (ui_beat_o.last || ui_cnt < blk))
    else $error("bulk-in packet exceeds block size");

  rx_commit_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R4]
    rx_wr && rf.last && !ui_ack |=> rx_held == $past(rx_held + rx_pend) + 1'b1)
    else $error("received frame not committed");

endmodule // upf_packet_fifo
`default_nettype wire
